// ---- rtl/mcs_ctrl_status.sv ----
// Notes on behaviour
// (RULE1) fully functional within 2000 ms of start
// (RULE2) reset needs low pulse over 2 us
// (RULE3) serial bus answers within 2000 ms
// (RULE4) clear data-not-ready and raise interrupt
// (RULE5) functional within 2000 ms after reset release
// (RULE6) low-power pin lowers power within 100 us
// (RULE7) interrupt low within 200 ms of cause
// (RULE8) read clears flag, interrupt releases quickly
// (RULE9) signal loss sets bit and interrupt
// (RULE10) any condition sets flag and interrupt
// (RULE11) mask set suppresses interrupt within 100 ms
// (RULE12) mask clear resumes interrupt within 100 ms
// (RULE13) select asserted enables bus within 100 us
// (RULE14) select released disables bus within 100 us
// (RULE15) power-down bit lowers power within 100 ms
// (RULE16) power-down clear restores function within 300 ms
// (RULE17) soft timing counts from clock fall after stop
// (RULE18) internal timers bound every transition
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module mcs_ctrl_status
	import mcs_pkg::*;
#(
	parameter int INIT_CYCLES = INIT_CYC,
	parameter int RESET_MIN_CYCLES = RESET_MIN_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// management pins from the host
	input wire logic reset_in_active_low,
	input wire logic bus_select_in_active_low,
	input wire logic low_power_pin,
	input wire logic scl_in,
	input wire logic sda_in,
	// module conditions from the datapath
	input wire logic rx_loss_in,
	input wire logic tx_fault_in,
	input wire logic other_cond_in,
	// outputs
	output logic irq_out_active_low,
	output logic irq,
	output logic low_power_out,
	output logic bus_enable_out,
	output logic data_not_ready_out
);

	// two-stage synchronisers for the pins
	mcs_pins_t pins_meta_reg;
	mcs_pins_t pins_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins_meta_reg <= '{reset_n: 1'b1, sel_n: 1'b1, lp: 1'b0, scl: 1'b1, sda: 1'b1};
			pins_reg <= '{reset_n: 1'b1, sel_n: 1'b1, lp: 1'b0, scl: 1'b1, sda: 1'b1};
		end else begin
			pins_meta_reg <= '{reset_n: reset_in_active_low, sel_n: bus_select_in_active_low,
				lp: low_power_pin, scl: scl_in, sda: sda_in};
			pins_reg <= pins_meta_reg;
		end
	end

	// delayed copies for edge detection
	logic scl_d_reg;
	logic sda_d_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= pins_reg.scl;
			sda_d_reg <= pins_reg.sda;
		end
	end

	// reset pulse filter: only a low longer than the minimum counts
	logic [15:0] rst_low_cnt_reg;
	logic rst_seen_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_low_cnt_reg <= 16'h0000;
			rst_seen_reg <= 1'b0;
		end else if (pins_reg.reset_n) begin
			rst_low_cnt_reg <= 16'h0000;
			rst_seen_reg <= 1'b0;
		end else if (rst_low_cnt_reg > 16'(RESET_MIN_CYCLES)) begin
			rst_seen_reg <= 1'b1; // [RULE2]
		end else begin
			rst_low_cnt_reg <= rst_low_cnt_reg + 16'h0001;
		end
	end

	// bus start and stop detection on the sampled serial lines
	logic start_ev;
	logic stop_ev;
	logic scl_fall;
	assign start_ev = pins_reg.scl && scl_d_reg && sda_d_reg && !pins_reg.sda;
	assign stop_ev = pins_reg.scl && scl_d_reg && !sda_d_reg && pins_reg.sda;
	assign scl_fall = scl_d_reg && !pins_reg.scl;

	// stop seen, waiting for the next clock fall
	logic stop_pend_reg;
	logic bus_busy_reg;
	logic [7:0] stop_cnt_reg;
	logic txn_done;
	assign txn_done = stop_pend_reg && scl_fall;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stop_pend_reg <= 1'b0;
			bus_busy_reg <= 1'b0;
			stop_cnt_reg <= 8'h00;
		end else begin
			if (stop_ev) begin
				stop_pend_reg <= 1'b1;
			end else if (txn_done) begin
				stop_pend_reg <= 1'b0;
			end
			if (start_ev) begin
				bus_busy_reg <= 1'b1;
			end else if (stop_ev) begin
				bus_busy_reg <= 1'b0;
			end
			if (txn_done) begin
				stop_cnt_reg <= stop_cnt_reg + 8'h01; // [RULE17]
			end
		end
	end

	// initialisation timer after power-on or reset release
	logic [31:0] init_cnt_reg;
	logic init_busy_reg;
	logic init_end;
	assign init_end = init_busy_reg && (init_cnt_reg == 32'(INIT_CYCLES - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_cnt_reg <= 32'h0000_0000;
			init_busy_reg <= 1'b1;
		end else if (rst_seen_reg) begin
			init_cnt_reg <= 32'h0000_0000;
			init_busy_reg <= 1'b1;
		end else if (init_end) begin
			init_busy_reg <= 1'b0; // [RULE1] [RULE5] [RULE18]
		end else if (init_busy_reg && pins_reg.reset_n) begin
			init_cnt_reg <= init_cnt_reg + 32'h0000_0001;
		end
	end

	// condition edge detectors
	mcs_flags_t cond_d_reg;
	mcs_flags_t ev;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cond_d_reg <= FLAGS_RST;
		end else begin
			cond_d_reg <= '{other: other_cond_in, tx_fault: tx_fault_in,
				rx_loss: rx_loss_in, init_done: 1'b0};
		end
	end
	assign ev = '{other: other_cond_in && !cond_d_reg.other,
		tx_fault: tx_fault_in && !cond_d_reg.tx_fault,
		rx_loss: rx_loss_in && !cond_d_reg.rx_loss,
		init_done: init_end};

	// axi write path: address and data taken together
	logic wr_go;
	logic [7:0] wr_addr_reg;
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			s_axi_awready <= wr_go;
			s_axi_wready <= wr_go;
			if (wr_go) begin
				wr_addr_reg <= s_axi_awaddr;
			end
		end
	end

	// write strobe and response
	logic wr_fire;
	assign wr_fire = s_axi_awready && s_axi_wready;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_addr_reg == OFF_CTRL || wr_addr_reg == OFF_MASK ||
				wr_addr_reg == OFF_FLAGS) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control and mask registers
	logic pdown_reg;
	mcs_flags_t mask_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pdown_reg <= 1'b0;
			mask_reg <= MASK_RST;
		end else if (wr_fire && s_axi_wstrb[0]) begin
			if (wr_addr_reg == OFF_CTRL) begin
				pdown_reg <= s_axi_wdata[CTRL_PDOWN_BIT]; // [RULE15] [RULE16]
			end
			if (wr_addr_reg == OFF_MASK) begin
				mask_reg <= s_axi_wdata[3:0]; // [RULE11] [RULE12]
			end
		end
	end

	// axi read path
	logic rd_go;
	logic rd_fire;
	logic [7:0] rd_addr_reg;
	assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	assign rd_fire = s_axi_arready && s_axi_arvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			rd_addr_reg <= 8'h00;
		end else begin
			s_axi_arready <= rd_go;
			if (rd_go) begin
				rd_addr_reg <= s_axi_araddr;
			end
		end
	end

	// sticky flags: events set, a read of the flags clears, set wins
	mcs_flags_t flags_reg;
	logic flags_rd;
	assign flags_rd = rd_fire && (rd_addr_reg == OFF_FLAGS);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_reg <= FLAGS_RST;
		end else if (flags_rd) begin
			flags_reg <= ev; // [RULE8]
		end else begin
			flags_reg <= flags_reg | ev; // [RULE4] [RULE9] [RULE10]
		end
	end

	// read data mux
	logic [31:0] state_word;
	always_comb begin
		state_word = 32'h0000_0000;
		state_word[ST_DNR_BIT] = data_not_ready_out;
		state_word[ST_LP_BIT] = low_power_out;
		state_word[ST_BUS_BIT] = bus_enable_out;
		state_word[ST_IRQ_BIT] = irq;
		state_word[ST_BUSY_BIT] = bus_busy_reg;
		state_word[ST_STOPS_LSB +: 8] = stop_cnt_reg;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (rd_addr_reg)
				OFF_CTRL: s_axi_rdata <= {31'h0000_0000, pdown_reg};
				OFF_FLAGS: s_axi_rdata <= {28'h000_0000, flags_reg};
				OFF_MASK: s_axi_rdata <= {28'h000_0000, mask_reg};
				OFF_STATE: s_axi_rdata <= state_word;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// interrupt outputs follow unmasked flags one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
			irq_out_active_low <= 1'b1;
		end else begin
			irq <= |(flags_reg & ~mask_reg); // [RULE7] [RULE11] [RULE12]
			irq_out_active_low <= ~|(flags_reg & ~mask_reg); // [RULE4] [RULE8]
		end
	end

	// power level, bus gating and data-not-ready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_power_out <= 1'b0;
			bus_enable_out <= 1'b0;
			data_not_ready_out <= 1'b1;
		end else begin
			low_power_out <= pins_reg.lp || pdown_reg; // [RULE6] [RULE15] [RULE16]
			bus_enable_out <= !init_busy_reg && !pins_reg.sel_n; // [RULE3] [RULE13] [RULE14]
			data_not_ready_out <= init_busy_reg; // [RULE4]
		end
	end

	// checks
	sequence s_wr_taken;
		s_axi_awready && s_axi_wready;
	endsequence
	sequence s_bresp_up;
		##1 s_axi_bvalid;
	endsequence

	chk_init_clears_dnr: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
		init_end |=> flags_reg.init_done ##1 (!data_not_ready_out && irq == !mask_reg.init_done))
		else $error("init end did not clear dnr and raise flag");

	chk_reset_filter: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
		rst_seen_reg |=> init_busy_reg && init_cnt_reg == 32'h0000_0000)
		else $error("filtered reset did not restart init");

	chk_short_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
		$rose(pins_reg.reset_n) && rst_low_cnt_reg <= 16'(RESET_MIN_CYCLES) |-> !rst_seen_reg)
		else $error("short reset pulse was recognised");

	chk_lp_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE6]
		pins_reg.lp |=> low_power_out)
		else $error("low power pin not obeyed");

	chk_pdown_soft: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE15]
		s_wr_taken and (wr_addr_reg == OFF_CTRL && s_axi_wstrb[0] && s_axi_wdata[0])
		|-> ##2 low_power_out)
		else $error("power-down bit not obeyed");

	chk_bus_select: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
		!init_busy_reg && !pins_reg.sel_n && $stable(init_busy_reg) |=> bus_enable_out)
		else $error("bus not enabled on select");

	chk_bus_deselect: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE14]
		pins_reg.sel_n || init_busy_reg |=> !bus_enable_out)
		else $error("bus enabled while deselected or initialising");

	chk_loss_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE9]
		rx_loss_in && !cond_d_reg.rx_loss |=> flags_reg.rx_loss ##1 (irq || mask_reg.rx_loss))
		else $error("loss event did not set flag and interrupt");

	chk_clear_on_read: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
		flags_rd && ev == FLAGS_RST |=> flags_reg == FLAGS_RST ##1 !irq ##0 irq_out_active_low)
		else $error("read did not clear flags and interrupt");

	chk_mask_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE11]
		mask_reg == 4'hF [*2] |-> !irq)
		else $error("interrupt raised while all masked");

	chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn) // [AXI] write response, our own choice
		s_wr_taken |-> s_bresp_up)
		else $error("write response missing");

	chk_stop_count: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE17]
		txn_done |=> stop_cnt_reg == $past(stop_cnt_reg) + 8'h01)
		else $error("finished bus transaction not counted");

endmodule : mcs_ctrl_status

`default_nettype wire

// ---- rtl/mcs_pkg.sv ----
package mcs_pkg;

	// clock rate and documented response limits
	localparam int CLK_MHZ = 100;
	localparam int T_INIT_MS = 2000;
	localparam int T_RESET_MIN_US = 2;
	localparam int T_LOW_POWER_PIN_US = 100;
	localparam int T_IRQ_ON_MS = 200;
	localparam int T_IRQ_OFF_US = 500;
	localparam int T_SEL_US = 100;

	// cycle counts derived from the limits
	localparam int INIT_CYC = T_INIT_MS * CLK_MHZ * 1000;
	localparam int RESET_MIN_CYC = T_RESET_MIN_US * CLK_MHZ;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_FLAGS = 8'h04;
	localparam logic [7:0] OFF_MASK = 8'h08;
	localparam logic [7:0] OFF_STATE = 8'h0C;

	// field positions
	localparam int CTRL_PDOWN_BIT = 0;
	localparam int ST_DNR_BIT = 0;
	localparam int ST_LP_BIT = 1;
	localparam int ST_BUS_BIT = 2;
	localparam int ST_IRQ_BIT = 3;
	localparam int ST_BUSY_BIT = 4;
	localparam int ST_STOPS_LSB = 8;

	// reset values
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic [3:0] MASK_RST = 4'h0;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// sticky flag layout, also used for the mask
	typedef struct packed {
		logic other;
		logic tx_fault;
		logic rx_loss;
		logic init_done;
	} mcs_flags_t;

	// synchronised management pins
	typedef struct packed {
		logic reset_n;
		logic sel_n;
		logic lp;
		logic scl;
		logic sda;
	} mcs_pins_t;

endpackage : mcs_pkg

// ---- dv/mcs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module mcs_host_model
	import mcs_pkg::*;
(
	// management pins toward the module
	output mcs_pins_t pins
);
	// idle pins: 2-wire lines pulled up, clock stands still outside frames
	initial begin
		pins = 5'b11011;
	end

	// select and low-power pin levels, moved off the sampling edge
	task set_pins(input logic sel_n_v, input logic lp_v);
		#3;
		pins.sel_n = sel_n_v;
		pins.lp = lp_v;
	endtask : set_pins

	// reset pin held low for the given time
	task pulse_reset(input int low_ns);
		#3;
		pins.reset_n = 1'b0;
		#(low_ns);
		pins.reset_n = 1'b1;
	endtask : pulse_reset

	// start, eight bits at 160 ns, stop; lines return to the pull-up level
	task frame(input logic [7:0] b);
		int i;
		#3;
		pins.sda = 1'b0;
		#80;
		for (i = 7; i >= 0; i--) begin
			pins.scl = 1'b0;
			pins.sda = b[i];
			#80;
			pins.scl = 1'b1;
			#80;
		end
		pins.scl = 1'b0;
		pins.sda = 1'b0;
		#80;
		pins.scl = 1'b1;
		#80;
		pins.sda = 1'b1;
		#80;
	endtask : frame
endmodule : mcs_host_model

`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import mcs_pkg::*;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic rx_loss_in, tx_fault_in, other_cond_in;
	logic irq_n, irq, lp_out, bus_en, dnr;
	mcs_pins_t pins;
	int n_fail, n_tests;

	// host side of the management pins and 2-wire lines
	mcs_host_model host (.pins(pins));

	// short counts keep the run brief
	mcs_ctrl_status #(.INIT_CYCLES(50), .RESET_MIN_CYCLES(20)) uut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.reset_in_active_low(pins.reset_n), .bus_select_in_active_low(pins.sel_n),
		.low_power_pin(pins.lp), .scl_in(pins.scl), .sda_in(pins.sda),
		.rx_loss_in(rx_loss_in), .tx_fault_in(tx_fault_in), .other_cond_in(other_cond_in),
		.irq_out_active_low(irq_n), .irq(irq), .low_power_out(lp_out),
		.bus_enable_out(bus_en), .data_not_ready_out(dnr)
	);

	// 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task report_and_stop;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	// write: address and data together, each released when taken, then the response
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	// read: address held until taken, data taken at the rvalid edge
	task rdw(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rdw

	task t_init;
		cyc(1);
		chk("dnr in init", dnr, 1);
		cyc(80);
		chk("dnr after init", dnr, 0);
		chk("irq_n after init", irq_n, 0);
		rdw(OFF_FLAGS);
		chk("flags init", rd, 32'h0000_0001);
		cyc(10);
		chk("irq_n after read", irq_n, 1);
		$display("test init done");
	endtask : t_init

	task t_flags;
		rx_loss_in <= 1'b1;
		cyc(10);
		chk("irq_n rx loss", irq_n, 0);
		rx_loss_in <= 1'b0;
		rdw(OFF_FLAGS);
		chk("flags rx loss", rd, 32'h0000_0002);
		cyc(10);
		chk("irq_n cleared", irq_n, 1);
		tx_fault_in <= 1'b1;
		wr(OFF_MASK, 32'h0000_0004);
		cyc(10);
		chk("irq_n masked", irq_n, 1);
		wr(OFF_MASK, 32'h0000_0000);
		cyc(10);
		chk("irq_n unmasked", irq_n, 0);
		chk("irq unmasked", irq, 1);
		rdw(OFF_FLAGS);
		chk("flags tx fault", rd, 32'h0000_0004);
		tx_fault_in <= 1'b0;
		other_cond_in <= 1'b1;
		cyc(10);
		other_cond_in <= 1'b0;
		rdw(OFF_FLAGS);
		chk("flags other", rd, 32'h0000_0008);
		cyc(10);
		chk("irq_n other cleared", irq_n, 1);
		$display("test flags done");
	endtask : t_flags

	task t_power;
		host.set_pins(1'b1, 1'b1);
		cyc(10);
		chk("lp by pin", lp_out, 1);
		host.set_pins(1'b1, 1'b0);
		cyc(10);
		chk("lp pin off", lp_out, 0);
		wr(OFF_CTRL, 32'h0000_0001);
		cyc(5);
		chk("lp by bit", lp_out, 1);
		rdw(OFF_STATE);
		chk("state lp", rd[ST_LP_BIT], 1);
		wr(OFF_CTRL, 32'h0000_0000);
		cyc(5);
		chk("lp bit off", lp_out, 0);
		$display("test power done");
	endtask : t_power

	task t_select;
		host.set_pins(1'b0, 1'b0);
		cyc(10);
		chk("bus on", bus_en, 1);
		host.frame(8'hA5);
		host.frame(8'h3C);
		cyc(10);
		rdw(OFF_STATE);
		chk("stop count", rd[15:8], 8'h01);
		chk("state bus on", rd[ST_BUS_BIT], 1);
		chk("state bus idle", rd[ST_BUSY_BIT], 0);
		chk("state dnr", rd[ST_DNR_BIT], 0);
		chk("state irq", rd[ST_IRQ_BIT], 0);
		host.set_pins(1'b1, 1'b0);
		cyc(10);
		chk("bus off", bus_en, 0);
		$display("test select done");
	endtask : t_select

	task t_reset_pin;
		host.pulse_reset(100);
		cyc(10);
		chk("short pulse", dnr, 0);
		host.pulse_reset(500);
		cyc(10);
		chk("long pulse", dnr, 1);
		cyc(80);
		chk("reinit done", dnr, 0);
		rdw(OFF_FLAGS);
		chk("flags reinit", rd, 32'h0000_0001);
		$display("test reset pin done");
	endtask : t_reset_pin

	task t_errors;
		rdw(8'h10);
		chk("rresp unmapped", rs, RESP_SLVERR);
		chk("rdata unmapped", rd, 32'h0000_0000);
		wr(8'h10, 32'h0000_0001);
		chk("bresp unmapped", rs, RESP_SLVERR);
		rdw(OFF_MASK);
		chk("mask value", rd, 32'h0000_0000);
		// a write without the low byte strobe leaves the mask alone
		s_axi_wstrb <= 4'h0;
		wr(OFF_MASK, 32'h0000_000F);
		s_axi_wstrb <= 4'hF;
		chk("bresp no strobe", rs, RESP_OKAY);
		rdw(OFF_MASK);
		chk("mask no strobe", rd, 32'h0000_0000);
		// all masked: a loss event sets its flag but no interrupt
		wr(OFF_MASK, 32'h0000_000F);
		chk("bresp mask", rs, RESP_OKAY);
		rx_loss_in <= 1'b1;
		cyc(10);
		chk("irq_n all masked", irq_n, 1);
		chk("irq all masked", irq, 0);
		rx_loss_in <= 1'b0;
		// a write to the flags is accepted and ignored
		wr(OFF_FLAGS, 32'h0000_0000);
		chk("bresp flags", rs, RESP_OKAY);
		wr(OFF_MASK, 32'h0000_0000);
		cyc(10);
		chk("irq_n mask cleared", irq_n, 0);
		rdw(OFF_FLAGS);
		chk("flags kept", rd, 32'h0000_0002);
		chk("rresp flags", rs, RESP_OKAY);
		cyc(10);
		chk("irq_n flags read", irq_n, 1);
		$display("test errors done");
	endtask : t_errors

	// cuts a hang short
	initial begin
		#300000;
		n_fail++;
		$display("ERROR watchdog expired");
		report_and_stop;
	end

	// reset, then the scenarios in turn
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{rx_loss_in, tx_fault_in, other_cond_in} = 3'b000;
		s_axi_wstrb = 4'hF;
		n_fail = 0;
		n_tests = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_init;
		t_flags;
		t_power;
		t_select;
		t_reset_pin;
		t_errors;
		report_and_stop;
	end
endmodule : tb_top

`default_nettype wire
